// file: src/board_io_defs.vh
// Constants for the board I/O latch port controller.
`ifndef BOARD_IO_DEFS_VH
`define BOARD_IO_DEFS_VH
`define IO_ADDR 16'h4000
`define BIT_IND_FIRST 0
`define BIT_IND_SECOND 1
`define BIT_SENSOR_EN 2
`define BIT_BUTTON 0
`define LATCH_INIT 8'h00
`define STROBE_MIN_NS 32
`define CLK_PERIOD_NS 40
// Strobe minimum is 3.2 ns, kept in tenths of a nanosecond to stay integer.
`define STROBE_CYCLES ((`STROBE_MIN_NS + `CLK_PERIOD_NS * 10 - 1) / (`CLK_PERIOD_NS * 10))
`define SETUP_CYCLES 3'h1
`define READ_WAIT_CYCLES 3'h3
`endif

// file: src/strobe_gen.v
// Strobe pulse generator that holds the select high for a set number of cycles.
`timescale 1ns/100ps
module strobe_gen (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Control
  input wire start,
  output reg busy_q,
  output reg pulse_q
);
`include "board_io_defs.vh"
  // At least one cycle, even where one clock period alone covers the minimum width.
  localparam [31:0] PULSE_RAW = (`STROBE_CYCLES < 1) ? 1 : `STROBE_CYCLES;
  localparam [2:0] PULSE_LEN = PULSE_RAW[2:0];
  reg [2:0] cnt_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      pulse_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (start && !busy_q) begin
      cnt_q <= PULSE_LEN;
      pulse_q <= 1'b1; // R4
      busy_q <= 1'b1;
    end else if (cnt_q > 3'h1) begin
      cnt_q <= cnt_q - 3'h1;
    end else if (cnt_q == 3'h1) begin
      cnt_q <= 3'h0;
      pulse_q <= 1'b0;
    end else begin
      busy_q <= 1'b0;
    end
  end
endmodule // strobe_gen

// file: src/board_io_host.v
// Host-side controller for the board I/O latch port at the on-board I/O address.
// Summary of operation
// [R1] Reading the I/O address returns the push-button level on data bit 0.
// [R2] A pressed push-button pulls its line low, so pressed reads as zero.
// [R3] Host writes the I/O address; the latch applies all output bits together.
// [R4] Output state is captured by a high strobe of at least 3.2 ns.
// [R5] Data goes on the bus first, then select rises, then falls.
// [R6] The latch cannot be read back, so the host keeps a mirror copy.
// [R7] A single-bit change rewrites the other latch bits with their mirrored values.
// [R8] Latch bit 0 drives the first indicator, bit 1 the second.
// [R9] Latch bit 2 set enables the fast buffer onto the third analog input.
// [R10] Latch bit 2 clear leaves the fast buffer output high impedance.
// [R11] After reset the host writes a known value to the latch and mirror.

`timescale 1ns/100ps

module board_io_host (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // User commands
  input wire cmd_write,
  input wire cmd_set_bit,
  input wire [2:0] cmd_bit_idx,
  input wire cmd_bit_val,
  input wire [7:0] cmd_wdata,
  input wire cmd_read,
  output reg cmd_busy_q,
  output reg cmd_done_q,
  output reg [7:0] mirror_q,
  output reg [7:0] rdata_q,
  output reg button_pressed_q,
  output reg indicator_first_q,
  output reg indicator_second_q,
  output reg sensor_buffer_en_q,
  // Device bus
  output reg [15:0] bus_addr_q,
  output reg [7:0] bus_dout_q,
  output reg bus_dout_oe_n_q,
  input wire [7:0] bus_din,
  output reg bus_rd_q,
  output reg io_select_q
);

`include "board_io_defs.vh"

  // ----------------------------------------------------------------
  // State encoding
  // ----------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_SETUP = 5'h02;
  localparam [4:0] ST_STROBE = 5'h04;
  localparam [4:0] ST_READ = 5'h08;
  localparam [4:0] ST_SAMPLE = 5'h10;

  reg [4:0] state_q;
  reg [2:0] wait_q;
  reg init_q;
  reg strobe_start_q;
  reg [7:0] din_s1_q;
  reg [7:0] din_s2_q;

  wire strobe_busy;
  wire strobe_pulse;
  wire apply_now;
  wire sample_now;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Merge one bit into the mirror so the other bits keep their value.
  function [7:0] merge_bit;
    input [7:0] base;
    input [2:0] idx;
    input val;
    begin
      merge_bit = base;
      merge_bit[idx] = val;
    end
  endfunction

  // ----------------------------------------------------------------
  // Strobe pulse generator
  // ----------------------------------------------------------------
  strobe_gen u_strobe (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(strobe_start_q),
    .busy_q(strobe_busy),
    .pulse_q(strobe_pulse)
  );

  // ----------------------------------------------------------------
  // Input synchroniser for the device data bus
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      din_s1_q <= 8'h00;
      din_s2_q <= 8'h00;
    end else begin
      din_s1_q <= bus_din;
      din_s2_q <= din_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  // The latch is only counted as written once the select has fallen again.
  assign apply_now = (state_q == ST_STROBE) && !strobe_start_q && !strobe_busy && !io_select_q;
  assign sample_now = (state_q == ST_SAMPLE);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      wait_q <= 3'h0;
      init_q <= 1'b1;
      strobe_start_q <= 1'b0;
      cmd_busy_q <= 1'b1;
      cmd_done_q <= 1'b0;
      bus_addr_q <= 16'h0000;
      bus_dout_q <= 8'h00;
      bus_dout_oe_n_q <= 1'b1;
      bus_rd_q <= 1'b0;
      io_select_q <= 1'b0;
    end else begin
      cmd_done_q <= 1'b0;
      strobe_start_q <= 1'b0;
      io_select_q <= strobe_pulse; // R4
      case (state_q)
        ST_IDLE: begin
          bus_dout_oe_n_q <= 1'b1;
          bus_rd_q <= 1'b0;
          if (init_q || cmd_write || cmd_set_bit) begin
            // Data first, select later, so the latch never sees a half-driven bus.
            bus_addr_q <= `IO_ADDR; // R3
            bus_dout_oe_n_q <= 1'b0; // R5
            if (init_q)
              bus_dout_q <= `LATCH_INIT; // R11
            else if (cmd_write)
              bus_dout_q <= cmd_wdata;
            else
              bus_dout_q <= merge_bit(mirror_q, cmd_bit_idx, cmd_bit_val); // R7
            wait_q <= `SETUP_CYCLES;
            cmd_busy_q <= 1'b1;
            state_q <= ST_SETUP;
          end else if (cmd_read) begin
            bus_addr_q <= `IO_ADDR;
            bus_rd_q <= 1'b1;
            wait_q <= `READ_WAIT_CYCLES;
            cmd_busy_q <= 1'b1;
            state_q <= ST_READ;
          end else begin
            cmd_busy_q <= 1'b0;
          end
        end
        ST_SETUP: begin
          if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
          end else begin
            strobe_start_q <= 1'b1;
            state_q <= ST_STROBE;
          end
        end

        ST_STROBE: begin
          // Data stays driven until the select has fallen again.
          if (apply_now) begin
            bus_dout_oe_n_q <= 1'b1;
            init_q <= 1'b0;
            cmd_done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_READ: begin
          // Two synchroniser stages plus one cycle of bus settling.
          if (wait_q != 3'h0)
            wait_q <= wait_q - 3'h1;
          else
            state_q <= ST_SAMPLE;
        end

        ST_SAMPLE: begin
          bus_rd_q <= 1'b0;
          cmd_done_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Board output and read-back registers
  // ----------------------------------------------------------------
  // The three board outputs move on one edge, like the latch they copy.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mirror_q <= `LATCH_INIT;
      indicator_first_q <= 1'b0;
      indicator_second_q <= 1'b0;
      sensor_buffer_en_q <= 1'b0;
      rdata_q <= 8'h00;
      button_pressed_q <= 1'b0;
    end else begin
      if (apply_now) begin
        mirror_q <= bus_dout_q; // R6
        indicator_first_q <= bus_dout_q[`BIT_IND_FIRST]; // R8
        indicator_second_q <= bus_dout_q[`BIT_IND_SECOND]; // R8
        sensor_buffer_en_q <= bus_dout_q[`BIT_SENSOR_EN]; // R3 R9 R10
      end
      // Raw byte kept for software; only the button bit is inverted.
      if (sample_now) begin
        rdata_q <= din_s2_q;
        button_pressed_q <= ~din_s2_q[`BIT_BUTTON]; // R1 R2
      end
    end
  end

endmodule // board_io_host

// file: sim/board_io_host_chk.sv
// Concurrent checks on the ports of the board I/O host controller.
`timescale 1ns/100ps
module board_io_host_chk (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Watched outputs
  input wire cmd_done_q,
  input wire [7:0] mirror_q,
  input wire indicator_first_q,
  input wire indicator_second_q,
  input wire sensor_buffer_en_q,
  input wire [15:0] bus_addr_q,
  input wire [7:0] bus_dout_q,
  input wire bus_dout_oe_n_q,
  input wire io_select_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence sel_pulse;
    $rose(io_select_q) ##1 $fell(io_select_q);
  endsequence
  strobe_width_a: assert property ($rose(io_select_q) |-> sel_pulse)
    else $error("strobe width wrong");
  data_first_a: assert property ($rose(io_select_q) |-> $past(bus_dout_oe_n_q, 2) == 1'b0)
    else $error("data not on bus before strobe");
  data_held_a: assert property (io_select_q |-> $stable(bus_dout_q) && bus_addr_q == 16'h4000)
    else $error("data or address moved under strobe");
  mirror_copy_a: assert property ($fell(io_select_q) |-> ##1 cmd_done_q && mirror_q == $past(bus_dout_q, 2))
    else $error("mirror differs from byte written");
  outputs_together_a: assert property ({sensor_buffer_en_q, indicator_second_q, indicator_first_q} == mirror_q[2:0])
    else $error("outputs split from mirror");
  init_write_a: assert property ($rose(rst_n) |-> ##[1:12] cmd_done_q && mirror_q == 8'h00)
    else $error("no initial latch write");
endmodule // board_io_host_chk

// file: sim/io_latch_model.sv
// Behavioural model of the board output latch and push-button.
`timescale 1ns/100ps
module io_latch_model (
  // Host bus
  input wire [15:0] bus_addr_q,
  input wire [7:0] bus_dout_q,
  input wire bus_dout_oe_n_q,
  input wire bus_rd_q,
  input wire io_select_q,
  output wire [7:0] bus_din,
  // Board side
  input wire user_pushbutton_n,
  output reg [7:0] latch_q,
  output wire [2:0] board_outs
);
  // The latch closes on the falling strobe; its power-up content stays unknown.
  always @(negedge io_select_q)
    if (bus_addr_q == 16'h4000 && !bus_dout_oe_n_q) latch_q <= bus_dout_q;
  // An idle bus shows the inverse, so a stale value can never pass.
  assign bus_din = (bus_rd_q && bus_addr_q == 16'h4000) ?
    {7'h2A, user_pushbutton_n} : {7'h55, ~user_pushbutton_n};
  assign board_outs = latch_q[2:0];
endmodule // io_latch_model

// file: sim/board_io_host_bench.sv
// Self-checking bench for the board I/O host controller.
`timescale 1ns/100ps
module board_io_host_bench;
  reg clk_sys = 1'b0, rst_n = 1'b0, user_pushbutton_n = 1'b1;
  reg cmd_write = 1'b0, cmd_set_bit = 1'b0, cmd_bit_val = 1'b0, cmd_read = 1'b0;
  reg [2:0] cmd_bit_idx = 3'h0;
  reg [7:0] cmd_wdata = 8'h00;
  reg [1:0] op;
  reg [21:0] rows [0:4];
  wire cmd_busy_q, cmd_done_q, button_pressed_q, indicator_first_q, indicator_second_q;
  wire sensor_buffer_en_q, bus_dout_oe_n_q, bus_rd_q, io_select_q;
  wire [7:0] mirror_q, rdata_q, bus_dout_q, bus_din, latch_q;
  wire [15:0] bus_addr_q;
  wire [2:0] board_outs;
  integer err_total = 0, n_tests = 0, cyc = 0, i;
  board_io_host u_dut (.*);
  io_latch_model u_dev (.*);
  always #20 clk_sys = ~clk_sys;
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task go(input w, input s, input r);
    begin
      while (cmd_busy_q !== 1'b0) @(negedge clk_sys);
      {cmd_write, cmd_set_bit, cmd_read} = {w, s, r};
      @(negedge clk_sys);
      {cmd_write, cmd_set_bit, cmd_read} = 3'h0;
      while (cmd_done_q !== 1'b1) @(negedge clk_sys);
    end
  endtask
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      results;
    end
  end
  initial begin
    rows[0] = {2'h1, 3'h0, 1'b0, 8'hF9, 8'hF9};
    rows[1] = {2'h2, 3'h2, 1'b1, 8'h00, 8'hFD};
    rows[2] = {2'h2, 3'h0, 1'b0, 8'h00, 8'hFC};
    rows[3] = {2'h2, 3'h1, 1'b1, 8'h00, 8'hFE};
    rows[4] = {2'h3, 3'h0, 1'b1, 8'h00, 8'h00};
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    while (cmd_busy_q !== 1'b0) @(negedge clk_sys);
    check(latch_q, 8'h00);
    for (i = 0; i < 5; i = i + 1) begin
      {op, cmd_bit_idx, cmd_bit_val, cmd_wdata} = rows[i][21:8];
      go(op[0], op[1], 1'b0);
      check(latch_q, rows[i][7:0]);
      check(mirror_q, rows[i][7:0]);
      check({5'h00, sensor_buffer_en_q, indicator_second_q, indicator_first_q}, {5'h00, rows[i][2:0]});
      check({5'h00, board_outs}, {5'h00, rows[i][2:0]});
      check({7'h00, board_outs[2]}, {7'h00, rows[i][2]});
    end
    for (i = 0; i < 2; i = i + 1) begin
      user_pushbutton_n = i[0];
      go(1'b0, 1'b0, 1'b1);
      check(rdata_q, {7'h2A, i[0]});
      check({7'h00, button_pressed_q}, {7'h00, ~i[0]});
    end
    // Commands raised while busy must be dropped, not queued.
    {cmd_wdata, cmd_bit_val} = {8'hAA, 1'b1};
    while (cmd_busy_q !== 1'b0) @(negedge clk_sys);
    cmd_write = 1'b1;
    @(negedge clk_sys);
    {cmd_write, cmd_set_bit, cmd_read} = 3'h3;
    @(negedge clk_sys);
    {cmd_set_bit, cmd_read} = 2'h0;
    while (cmd_done_q !== 1'b1) @(negedge clk_sys);
    check(latch_q, 8'hAA);
    repeat (3) @(negedge clk_sys);
    check({7'h00, cmd_busy_q}, 8'h00);
    // A reset in mid-run must restart with the initial latch write.
    rst_n = 1'b0;
    @(negedge clk_sys);
    check({6'h00, cmd_busy_q, bus_dout_oe_n_q}, 8'h03);
    check({5'h00, io_select_q, bus_rd_q, cmd_done_q}, 8'h00);
    check(mirror_q, 8'h00);
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    check({7'h00, cmd_busy_q}, 8'h01);
    while (cmd_busy_q !== 1'b0) @(negedge clk_sys);
    check(latch_q, 8'h00);
    check({5'h00, board_outs}, 8'h00);
    results;
  end
endmodule // board_io_host_bench
bind board_io_host board_io_host_chk u_chk (.clk_sys, .rst_n, .cmd_done_q, .mirror_q, .indicator_first_q,
  .indicator_second_q, .sensor_buffer_en_q, .bus_addr_q, .bus_dout_q, .bus_dout_oe_n_q, .io_select_q);
